// [design/adcr_cfg.svh]
// Constants of the converter result reporting block: addresses, fields, resets.
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADCR_GDAT_ADDR 32'h4001c014
`define ADCR_CHAN_BASE 32'h4001c020
`define ADCR_CTRL_ADDR 32'h4001c080
`define ADCR_THRL_ADDR 32'h4001c084
`define ADCR_THRH_ADDR 32'h4001c088
`define ADCR_FLAG_ADDR 32'h4001c08c
`define ADCR_NUM_CHAN 12

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCR_RES_LSB 4
`define ADCR_RANGE_LSB 16
`define ADCR_CROSS_LSB 18
`define ADCR_CHN_LSB 26
`define ADCR_OVR_BIT 30
`define ADCR_FRESH_BIT 31
`define ADCR_MODE_BIT 0
`define ADCR_CMPL_IE_BIT 1
`define ADCR_OVR_IE_BIT 2

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define ADCR_RANGE_IN 2'h0
`define ADCR_RANGE_BELOW 2'h1
`define ADCR_RANGE_ABOVE 2'h2
`define ADCR_CROSS_NONE 2'h0
`define ADCR_CROSS_DOWN 2'h2
`define ADCR_CROSS_UP 2'h3
`define ADCR_CTRL_RST 3'h0
`define ADCR_THRL_RST 12'h000
`define ADCR_THRH_RST 12'hfff

`endif

// [design/adcr_pkg.sv]
// Types shared by the converter result reporting block.
package adcr_pkg;
    typedef logic [11:0] adcr_sample_t;
    typedef logic [3:0] adcr_chan_t;
    typedef logic [1:0] adcr_code_t;
endpackage : adcr_pkg

// [design/adcr_top.sv]
// Converter result reporting: sequence B global register and channel registers.
`timescale 1ns/10ps
`default_nettype none
`include "adcr_cfg.svh"

module adcr_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire adcr_pkg::adcr_sample_t conv_result,
    input wire adcr_pkg::adcr_chan_t conv_channel,
    input wire logic conv_seq_b,
    output logic irq_seq_b_complete,
    output logic irq_overrun
);
    import adcr_pkg::*;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Maps an address onto a channel register: bit 4 is the hit, 3:0 the index.
    function automatic logic [4:0] chan_decode(input logic [31:0] addr);
        logic [31:0] off;
        off = addr - `ADCR_CHAN_BASE;
        chan_decode = 5'h00;
        if (addr >= `ADCR_CHAN_BASE && off[1:0] == 2'h0 && off[31:2] < 30'd12) begin
            chan_decode = {1'b1, off[5:2]};
        end
    endfunction : chan_decode

    // Range code against the window; both bounds are inclusive.
    function automatic adcr_code_t range_code(input adcr_sample_t v,
                                              input adcr_sample_t lo,
                                              input adcr_sample_t hi);
        if (v < lo) begin
            range_code = `ADCR_RANGE_BELOW;
        end else if (v > hi) begin
            range_code = `ADCR_RANGE_ABOVE;
        end else begin
            range_code = `ADCR_RANGE_IN;
        end
    endfunction : range_code

    // Crossing code from the previous and current relation to the low threshold.
    function automatic adcr_code_t cross_code(input logic prev_above, input logic cur_above);
        if (prev_above && !cur_above) begin
            cross_code = `ADCR_CROSS_DOWN;
        end else if (!prev_above && cur_above) begin
            cross_code = `ADCR_CROSS_UP;
        end else begin
            cross_code = `ADCR_CROSS_NONE;
        end
    endfunction : cross_code

    // Packs one result word; reserved bits read as zero.
    function automatic logic [31:0] pack_word(input adcr_sample_t res, input adcr_code_t rng,
                                              input adcr_code_t crs, input adcr_chan_t source_channel_field,
                                              input logic ovr, input logic fresh);
        pack_word = 32'h0000_0000;
        pack_word[`ADCR_RES_LSB +: 12] = res;
        pack_word[`ADCR_RANGE_LSB +: 2] = rng;
        pack_word[`ADCR_CROSS_LSB +: 2] = crs;
        pack_word[`ADCR_CHN_LSB +: 4] = source_channel_field;
        pack_word[`ADCR_OVR_BIT] = ovr;
        pack_word[`ADCR_FRESH_BIT] = fresh;
    endfunction : pack_word

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [2:0] ctrl_reg;
    adcr_sample_t thr_low_reg;
    adcr_sample_t thr_high_reg;
    adcr_sample_t g_res_reg;
    adcr_code_t g_range_reg;
    adcr_code_t g_cross_reg;
    adcr_chan_t g_chn_reg;
    logic g_fresh_reg;
    logic g_ovr_reg;
    adcr_sample_t ch_res_reg [`ADCR_NUM_CHAN];
    adcr_code_t ch_range_reg [`ADCR_NUM_CHAN];
    adcr_code_t ch_cross_reg [`ADCR_NUM_CHAN];
    logic [`ADCR_NUM_CHAN-1:0] ch_fresh_reg;
    logic [`ADCR_NUM_CHAN-1:0] ch_ovr_reg;
    logic [`ADCR_NUM_CHAN-1:0] prev_above_reg;

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // Reads act in the setup cycle, so the clear hits the same edge that samples the data.
    logic setup_rd;
    logic access_wr;
    logic [4:0] rd_chan;
    logic gdat_rd;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign access_wr = psel & penable & pwrite;
    assign rd_chan = chan_decode(paddr);
    assign gdat_rd = setup_rd && (paddr == `ADCR_GDAT_ADDR);

    // Every transfer completes without wait states.
    assign pready = psel & penable;

    // ****************************************************************
    // New sample evaluation
    // ****************************************************************

    // A channel number beyond the last channel updates the global register only.
    logic chan_ok;
    logic gdat_load;
    logic cur_above;
    logic prev_above;
    adcr_code_t new_range;
    adcr_code_t new_cross;
    assign chan_ok = conv_channel < 4'd12;
    assign gdat_load = conv_done & conv_seq_b;
    assign cur_above = conv_result >= thr_low_reg;
    assign prev_above = chan_ok ? prev_above_reg[conv_channel] : cur_above;
    assign new_range = range_code(conv_result, thr_low_reg, thr_high_reg);
    assign new_cross = cross_code(prev_above, cur_above);

    // ****************************************************************
    // Software controls
    // ****************************************************************

    // Mode and interrupt enables for sequence B.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `ADCR_CTRL_RST;
        end else if (access_wr && paddr == `ADCR_CTRL_ADDR) begin
            ctrl_reg <= pwdata[2:0];
        end
    end

    // Threshold window shared by all channels.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thr_low_reg <= `ADCR_THRL_RST;
            thr_high_reg <= `ADCR_THRH_RST;
        end else if (access_wr) begin
            if (paddr == `ADCR_THRL_ADDR) begin
                thr_low_reg <= pwdata[11:0];
            end
            if (paddr == `ADCR_THRH_ADDR) begin
                thr_high_reg <= pwdata[11:0];
            end
        end
    end

    // ****************************************************************
    // Sequence B global register
    // ****************************************************************

    // Result fields follow each sequence B conversion; the code is stored as delivered.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            g_res_reg <= 12'h000;
            g_range_reg <= `ADCR_RANGE_IN;
            g_cross_reg <= `ADCR_CROSS_NONE;
            g_chn_reg <= 4'h0;
        end else if (gdat_load) begin
            g_res_reg <= conv_result;
            g_range_reg <= new_range;
            g_cross_reg <= new_cross;
            g_chn_reg <= conv_channel;
        end
    end

    // A new result beats a read in the same cycle, so no sample is silently lost.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            g_fresh_reg <= 1'b0;
            g_ovr_reg <= 1'b0;
        end else begin
            if (gdat_load) begin
                g_fresh_reg <= 1'b1;
            end else if (gdat_rd) begin
                g_fresh_reg <= 1'b0;
            end
            if (gdat_load && g_fresh_reg) begin
                g_ovr_reg <= 1'b1;
            end else if (gdat_rd) begin
                g_ovr_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Channel registers
    // ****************************************************************

    // One register per channel, updated whatever sequence or trigger asked.
    generate
        for (genvar i = 0; i < `ADCR_NUM_CHAN; i++) begin : g_chan
            logic hit;
            logic rd;
            assign hit = conv_done && chan_ok && (conv_channel == 4'(i));
            assign rd = setup_rd && rd_chan[4] && (rd_chan[3:0] == 4'(i));

            // Result, codes and the relation kept for the next crossing test.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ch_res_reg[i] <= 12'h000;
                    ch_range_reg[i] <= `ADCR_RANGE_IN;
                    ch_cross_reg[i] <= `ADCR_CROSS_NONE;
                    prev_above_reg[i] <= 1'b0;
                end else if (hit) begin
                    ch_res_reg[i] <= conv_result;
                    ch_range_reg[i] <= new_range;
                    ch_cross_reg[i] <= new_cross;
                    prev_above_reg[i] <= cur_above;
                end
            end

            // Status flags; the channel read clears them like the global read.
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ch_fresh_reg[i] <= 1'b0;
                    ch_ovr_reg[i] <= 1'b0;
                end else begin
                    if (hit) begin
                        ch_fresh_reg[i] <= 1'b1;
                    end else if (rd) begin
                        ch_fresh_reg[i] <= 1'b0;
                    end
                    if (hit && ch_fresh_reg[i]) begin
                        ch_ovr_reg[i] <= 1'b1;
                    end else if (rd) begin
                        ch_ovr_reg[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read data and interrupt requests
    // ****************************************************************

    // Read word is sampled in the setup cycle and held through the access cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (rd_chan[4]) begin
                prdata <= pack_word(ch_res_reg[rd_chan[3:0]], ch_range_reg[rd_chan[3:0]],
                                    ch_cross_reg[rd_chan[3:0]], rd_chan[3:0],
                                    ch_ovr_reg[rd_chan[3:0]], ch_fresh_reg[rd_chan[3:0]]);
            end else begin
                case (paddr)
                    `ADCR_GDAT_ADDR: begin
                        prdata <= pack_word(g_res_reg, g_range_reg, g_cross_reg,
                                            g_chn_reg, g_ovr_reg, g_fresh_reg);
                    end
                    `ADCR_CTRL_ADDR: begin
                        prdata <= {29'h0, ctrl_reg};
                    end
                    `ADCR_THRL_ADDR: begin
                        prdata <= {20'h0, thr_low_reg};
                    end
                    `ADCR_THRH_ADDR: begin
                        prdata <= {20'h0, thr_high_reg};
                    end
                    `ADCR_FLAG_ADDR: begin
                        prdata <= {20'h0, ch_ovr_reg};
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Mode one hands the flags to channel-register readers, so they stop interrupting.
    assign irq_seq_b_complete = g_fresh_reg & ~ctrl_reg[`ADCR_MODE_BIT]
                                & ctrl_reg[`ADCR_CMPL_IE_BIT];
    assign irq_overrun = g_ovr_reg & ~ctrl_reg[`ADCR_MODE_BIT]
                         & ctrl_reg[`ADCR_OVR_IE_BIT];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_result_load: assert property (
        gdat_load |=> g_res_reg == $past(conv_result)
    ) else $error("global result not loaded");

    chk_fresh_set: assert property (
        gdat_load |=> g_fresh_reg
    ) else $error("fresh flag not set on load");

    chk_read_clear: assert property (
        gdat_rd && !gdat_load |=> !g_fresh_reg && !g_ovr_reg
    ) else $error("read did not clear flags");

    chk_overrun_set: assert property (
        gdat_load && g_fresh_reg |=> g_ovr_reg
    ) else $error("overrun not flagged");

    chk_ovr_request: assert property (
        gdat_load && g_fresh_reg && !ctrl_reg[`ADCR_MODE_BIT] && ctrl_reg[`ADCR_OVR_IE_BIT]
        && !(access_wr && paddr == `ADCR_CTRL_ADDR) |=> irq_overrun
    ) else $error("overrun request missing");

    chk_cmpl_request: assert property (
        gdat_load && !ctrl_reg[`ADCR_MODE_BIT] && ctrl_reg[`ADCR_CMPL_IE_BIT]
        && !(access_wr && paddr == `ADCR_CTRL_ADDR) |=> irq_seq_b_complete
    ) else $error("completion request missing");

    chk_range_legal: assert property (
        g_range_reg != 2'h3
    ) else $error("reserved range code");

    chk_range_inside: assert property (
        gdat_load && conv_result >= thr_low_reg && conv_result <= thr_high_reg
        |=> g_range_reg == 2'h0
    ) else $error("in range not reported");

    chk_cross_none: assert property (
        gdat_load && chan_ok && prev_above == cur_above |=> g_cross_reg == 2'h0
    ) else $error("false crossing reported");

    chk_chan_field: assert property (
        gdat_load |=> g_chn_reg == $past(conv_channel)
    ) else $error("channel field wrong");

    chk_chan_update: assert property (
        conv_done && conv_channel == 4'h0 |=> ch_res_reg[0] == $past(conv_result) && ch_fresh_reg[0]
    ) else $error("channel register not updated");

endmodule : adcr_top
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the converter result reporting block, driven over APB.
`timescale 1ns/10ps
`default_nettype none
`include "adcr_cfg.svh"

module tb;
    import adcr_pkg::*;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_done = 1'b0;
    adcr_pkg::adcr_sample_t conv_result = 12'h000;
    adcr_pkg::adcr_chan_t conv_channel = 4'h0;
    logic conv_seq_b = 1'b0;
    logic irq_seq_b_complete;
    logic irq_overrun;
    int err_total = 0;
    int n_checks = 0;
    // Reference state of the registers, kept by the bench from the expected behaviour.
    logic [31:0] m_glob = 32'h0;
    logic [31:0] m_chan [12];
    logic m_ab [12];
    logic [11:0] m_lo = 12'h000;
    logic [11:0] m_hi = 12'hfff;
    logic [2:0] m_ctrl = 3'h0;
    logic [11:0] tbl [7] = '{12'h3ff, 12'h400, 12'hc00, 12'hc01, 12'h3ff, 12'h000, 12'hfff};

    adcr_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .conv_result(conv_result), .conv_channel(conv_channel),
        .conv_seq_b(conv_seq_b), .irq_seq_b_complete(irq_seq_b_complete), .irq_overrun(irq_overrun));

    // Free-running 20 MHz clock.
    always #25 clk = ~clk;

    // ****************************************************************
    // Comparison, bus and conversion tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; every signal is held until pready is seen high at an edge.
    // The wait has no cycle limit of its own: only the watchdog ends a hung transfer.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        chk(pready, 1'b0);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic eslv);
        logic [31:0] v;
        logic e;
        apb(1'b0, a, 32'h0, v, e);
        chk(v, exp);
        chk(e, eslv);
    endtask : rd

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic eslv);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
        chk(e, eslv);
    endtask : wr

    // A read of a data register returns its flags and then clears them in the reference.
    task automatic rd_glob();
        rd(`ADCR_GDAT_ADDR, m_glob, 1'b0);
        m_glob[31:30] = 2'h0;
    endtask : rd_glob

    task automatic rd_chan(input int n);
        rd(`ADCR_CHAN_BASE + 32'(4 * n), m_chan[n], 1'b0);
        m_chan[n][31:30] = 2'h0;
    endtask : rd_chan

    task automatic rd_flags();
        logic [31:0] f;
        f = 32'h0;
        for (int i = 0; i < 12; i++) f[i] = m_chan[i][30];
        rd(`ADCR_FLAG_ADDR, f, 1'b0);
    endtask : rd_flags

    function automatic logic [31:0] mk(input logic [11:0] r, input logic [3:0] ch, input logic [1:0] cr,
                                       input logic [1:0] rg, input logic o, input logic f);
        return {f, o, ch, 6'h00, cr, rg, r, 4'h0};
    endfunction : mk

    // Drives one finished conversion and predicts range, crossing and flags from the thresholds.
    task automatic conv(input logic [3:0] ch, input logic [11:0] r, input logic b);
        logic ab;
        logic [1:0] rg;
        logic [1:0] cr;
        ab = (r >= m_lo);
        rg = (r < m_lo) ? 2'h1 : ((r > m_hi) ? 2'h2 : 2'h0);
        cr = (ab == m_ab[ch]) ? 2'h0 : (ab ? 2'h3 : 2'h2);
        m_ab[ch] = ab;
        m_chan[ch] = mk(r, ch, cr, rg, m_chan[ch][31] | m_chan[ch][30], 1'b1);
        if (b) m_glob = mk(r, ch, cr, rg, m_glob[31] | m_glob[30], 1'b1);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_result <= r;
        conv_channel <= ch;
        conv_seq_b <= b;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_seq_b <= 1'b0;
        // Let the edge's register updates land before looking at the requests.
        #1;
        chk(irq_seq_b_complete, m_glob[31] & ~m_ctrl[0] & m_ctrl[1]);
        chk(irq_overrun, m_glob[30] & ~m_ctrl[0] & m_ctrl[2]);
    endtask : conv

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        for (int i = 0; i < 12; i++) begin
            m_chan[i] = 32'h0;
            m_ab[i] = 1'b0;
        end
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        // Reset state and an unmapped place.
        rd(`ADCR_CTRL_ADDR, 32'h0, 1'b0);
        rd(`ADCR_THRL_ADDR, 32'h0, 1'b0);
        rd(`ADCR_THRH_ADDR, 32'h00000fff, 1'b0);
        rd_glob();
        rd_flags();
        rd(32'h4001c0fc, 32'h0, 1'b1);
        wr(32'h4001c0fc, 32'h1, 1'b1);
        // Window 0x400..0xc00, both requests enabled in per-conversion mode.
        m_lo = 12'h400;
        m_hi = 12'hc00;
        m_ctrl = 3'h6;
        wr(`ADCR_THRL_ADDR, 32'h400, 1'b0);
        wr(`ADCR_THRH_ADDR, 32'hc00, 1'b0);
        wr(`ADCR_CTRL_ADDR, 32'h6, 1'b0);
        rd(`ADCR_CTRL_ADDR, 32'h6, 1'b0);
        // Unread result is overwritten: overrun, then a read clears both flags.
        conv(4'h1, 12'h300, 1'b1);
        conv(4'h1, 12'h500, 1'b1);
        wr(`ADCR_GDAT_ADDR, 32'h0, 1'b0);
        rd_glob();
        rd_glob();
        chk(irq_seq_b_complete, 1'b0);
        chk(irq_overrun, 1'b0);
        // Boundary values around both thresholds on one channel.
        for (int i = 0; i < 7; i++) begin
            conv(4'h2, tbl[i], 1'b1);
            rd_glob();
        end
        rd_chan(2);
        // Every channel from the other sequence: the global register stays put.
        for (int i = 0; i < 12; i++) conv(4'(i), 12'(i * 12'h111), 1'b0);
        rd_glob();
        for (int i = 0; i < 12; i++) rd_chan(i);
        conv(4'h5, 12'h700, 1'b0);
        conv(4'h5, 12'h100, 1'b0);
        rd_flags();
        rd_chan(5);
        // Whole-sequence mode keeps both requests quiet.
        m_ctrl = 3'h7;
        wr(`ADCR_CTRL_ADDR, 32'h7, 1'b0);
        conv(4'h0, 12'h800, 1'b1);
        conv(4'h0, 12'h810, 1'b1);
        rd_glob();
        tally_and_finish();
    end

    // Watchdog: the sequence needs well under 5000 cycles.
    initial begin
        #(50 * 5000);
        err_total++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
